/* rtl/dslt_pkg.sv */
// package with register map, field layout and timing constants for the dual sheet line timer
package dslt_pkg;
  // ==========================================================================
  // register byte offsets (Avalon word aligned)
  localparam logic [5:0] OFS_CTRL     = 6'h00;
  localparam logic [5:0] OFS_LINE     = 6'h04;
  localparam logic [5:0] OFS_LINES    = 6'h08;
  localparam logic [5:0] OFS_PIXELS   = 6'h0C;
  localparam logic [5:0] OFS_EXPOSE   = 6'h10;
  localparam logic [5:0] OFS_DELAY    = 6'h14;
  localparam logic [5:0] OFS_WIDTH    = 6'h18;
  localparam logic [5:0] OFS_FRAME    = 6'h1C;
  localparam logic [5:0] OFS_STATUS   = 6'h20;
  localparam logic [5:0] OFS_EXPLIM   = 6'h24;
  // ==========================================================================
  // control field positions
  localparam int CTRL_RUN      = 0;
  localparam int CTRL_REF_LO   = 1;
  localparam int CTRL_DEPTH_LO = 3;
  localparam int CTRL_TOP_DIR  = 5;
  localparam int CTRL_BOT_DIR  = 6;
  localparam int CTRL_OPMODE_LO = 7;
  localparam int CTRL_BINNING  = 9;
  localparam int CTRL_W        = 10;
  // reference select codes
  localparam logic [1:0] REF_READ_END = 2'h0;
  localparam logic [1:0] REF_FRAME    = 2'h1;
  localparam logic [1:0] REF_LINE     = 2'h2;
  // output depth codes
  localparam logic [1:0] DEPTH_16 = 2'h0;
  localparam logic [1:0] DEPTH_12 = 2'h1;
  localparam logic [1:0] DEPTH_8  = 2'h2;
  // operation mode codes; level trigger (3) is refused
  localparam logic [1:0] OPM_FREE  = 2'h0;
  localparam logic [1:0] OPM_EDGE  = 2'h1;
  localparam logic [1:0] OPM_START = 2'h2;
  // ==========================================================================
  // band limits and time bounds, times in microseconds except TICK_NS and CLK_NS in nanoseconds
  localparam logic [15:0] WIDE_PIXELS  = 16'h0200; // 512
  localparam logic [15:0] MIN_LINES_16 = 16'h0008;
  localparam logic [15:0] MIN_LINES_12 = 16'h0010;
  localparam logic [15:0] MIN_LINES_8  = 16'h0030;
  localparam logic [15:0] LINE_EXTRA   = 16'h000A; // ten extra line periods
  localparam logic [7:0]  DIV_16 = 8'h28; // 40
  localparam logic [7:0]  DIV_12 = 8'h35; // 53
  localparam logic [7:0]  DIV_8  = 8'h50; // 80
  localparam logic [31:0] LINES_REF = 32'h0000_0400; // 1024
  localparam logic [31:0] MAX_TIME_US  = 32'h0098_9680; // 10 s
  localparam logic [31:0] MAX_LINE_US  = 32'h0001_86A0; // 100 ms
  localparam logic [31:0] MIN_WIDTH_US = 32'h0000_0001;
  localparam logic [31:0] US_PER_S     = 32'h000F_4240;
  localparam int CLOCK_MHZ = 250;
  localparam int TICK_NS   = 1000;
  localparam int CLK_NS    = 4;
  localparam int TICK_CYC  = (TICK_NS + CLK_NS - 1) / CLK_NS;
  // reset values
  localparam logic [31:0] LINE_RST   = 32'h0000_000A;
  localparam logic [31:0] LINES_RST  = 32'h0000_0400;
  localparam logic [31:0] PIXELS_RST = 32'h0000_0800;
  localparam logic [31:0] EXPOSE_RST = 32'h0000_2710;
  localparam logic [31:0] WIDTH_RST  = 32'h0000_000A;
endpackage

/* rtl/dslt_timer.sv */
// dual sheet line timer: frame period, exposure clamp and programmable pulse out
// ==========================================================================
// Summary of operation
// - software sets line period and exposure so readout tracks an illumination scan.
// - exposure parameter ranges up to ten seconds.
// - exposure clamped to one line up to readout time, or ten seconds if longer.
// - bandwidth period rounds the line count down; microsecond ticks round up.
// - 16 bit wide frames of 8+ lines use the divisor 40 limited period.
// - 12 bit wide frames of 16+ lines use the divisor 53 limited period.
// - 8 bit wide frames of 48+ lines use the divisor 80 limited period.
// - no global exposure output exists in this mode; it reads zero.
// - pulse delay 0 to 10 s, width 1 us to 10 s.
// - read end reference: pulse after delay from end of readout.
// - frame sync reference: pulse after delay from start of readout.
// - line sync reference: pulse after delay from every line sync; a sync that comes before the previous pulse has ended is dropped.
// - line sync pulses may lead readout start; treated as leading pulses.
// - top and bottom readout directions are set independently.
// - free, edge and start trigger only; binning requests are refused.
//
// Decided for this implementation: the placing of the registers and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
module dslt_timer #(
  parameter int unsigned TICK_CYCLES = dslt_pkg::TICK_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        reset,
  // avalon-mm slave
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // sensor trigger pin
  input  wire logic        trigger_in,
  // timing outputs
  output logic             pulse_out,
  output logic             frame_active,
  output logic             line_sync,
  output logic             top_dir,
  output logic             bottom_dir,
  output logic             global_exposure
);
  // the tick counter is 16 bits wide, so longer tick periods cannot be served
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65536) begin : g_bad_tick
    $error("TICK_CYCLES must lie between 1 and 65536");
  end

  typedef enum logic [1:0] {DSLT_IDLE, DSLT_EXPOSE, DSLT_READ} dslt_frame_t;
  typedef enum logic [1:0] {DSLT_P_IDLE, DSLT_P_DELAY, DSLT_P_HIGH} dslt_pulse_t;

  // clamp a value into [lo, hi]
  function automatic logic [31:0] clamp(input logic [31:0] v, input logic [31:0] lo,
                                        input logic [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction
  // merge write data with byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] be);
    for (int i = 0; i < 4; i++) merge[8*i +: 8] = be[i] ? d[8*i +: 8] : old[8*i +: 8];
  endfunction

  // ==========================================================================
  // registers
  logic [dslt_pkg::CTRL_W-1:0] ctrl_r;
  logic [31:0] line_r, lines_r, pixels_r, expose_r, delay_r, width_r;
  logic [31:0] frame_r, explim_r;
  logic        refused_r, ack_r, wait_r;
  logic [31:0] rdata_r;

  // ==========================================================================
  // bus decode
  wire        req      = (avs_read | avs_write) & ~ack_r;
  // a write lands at the edge that ends the wait state, the one where the master sees it done
  wire        wr       = avs_write & ack_r;
  wire [31:0] ctrl_w   = merge({22'h0, ctrl_r}, avs_writedata, avs_byteenable);
  // a write asking for binning or level trigger is refused whole
  wire        ctrl_bad = ctrl_w[dslt_pkg::CTRL_BINNING] |
                         (ctrl_w[dslt_pkg::CTRL_OPMODE_LO +: 2] == 2'h3);
  wire        run      = ctrl_r[dslt_pkg::CTRL_RUN];
  wire [1:0]  ref_sel  = ctrl_r[dslt_pkg::CTRL_REF_LO +: 2];
  wire [1:0]  depth    = ctrl_r[dslt_pkg::CTRL_DEPTH_LO +: 2];
  wire [1:0]  opmode   = ctrl_r[dslt_pkg::CTRL_OPMODE_LO +: 2];

  // one wait state: answer one cycle after the request is seen
  always_ff @(posedge clock) begin
    if (reset) begin
      ack_r  <= 1'b0;
      wait_r <= 1'b1;
    end else begin
      ack_r  <= req;
      wait_r <= ~req; // kept as its own flop so the output needs no gate
    end
  end

  // software written timing setup
  always_ff @(posedge clock) begin
    if (reset) begin
      ctrl_r    <= '0;
      refused_r <= 1'b0;
      line_r    <= dslt_pkg::LINE_RST;
      lines_r   <= dslt_pkg::LINES_RST;
      pixels_r  <= dslt_pkg::PIXELS_RST;
      expose_r  <= dslt_pkg::EXPOSE_RST;
      delay_r   <= '0;
      width_r   <= dslt_pkg::WIDTH_RST;
    end else if (wr) begin
      case (avs_address)
        dslt_pkg::OFS_CTRL: begin
          if (!ctrl_bad) ctrl_r <= ctrl_w[dslt_pkg::CTRL_W-1:0];
          refused_r <= ctrl_bad;
        end
        dslt_pkg::OFS_LINE:   line_r   <= clamp(merge(line_r, avs_writedata, avs_byteenable),
                                                dslt_pkg::MIN_WIDTH_US, dslt_pkg::MAX_LINE_US);
        dslt_pkg::OFS_LINES:  lines_r  <= merge(lines_r, avs_writedata, avs_byteenable);
        dslt_pkg::OFS_PIXELS: pixels_r <= merge(pixels_r, avs_writedata, avs_byteenable);
        dslt_pkg::OFS_EXPOSE: expose_r <= clamp(merge(expose_r, avs_writedata, avs_byteenable),
                                                '0, dslt_pkg::MAX_TIME_US);
        dslt_pkg::OFS_DELAY:  delay_r  <= clamp(merge(delay_r, avs_writedata, avs_byteenable),
                                                '0, dslt_pkg::MAX_TIME_US);
        dslt_pkg::OFS_WIDTH:  width_r  <= clamp(merge(width_r, avs_writedata, avs_byteenable),
                                                dslt_pkg::MIN_WIDTH_US,
                                                dslt_pkg::MAX_TIME_US);
        default: ;
      endcase
    end
  end

  // ==========================================================================
  // exposure limits and frame period
  wire [47:0] readout_w = lines_r * line_r; // readout time = lines x line period
  wire [31:0] exp_hi    = (readout_w < {16'h0, dslt_pkg::MAX_TIME_US}) ?
                          readout_w[31:0] : dslt_pkg::MAX_TIME_US;
  wire [31:0] exp_eff   = clamp(expose_r, line_r, exp_hi);
  wire        wide      = pixels_r > {16'h0, dslt_pkg::WIDE_PIXELS};
  wire [7:0]  divisor   = (depth == dslt_pkg::DEPTH_16) ? dslt_pkg::DIV_16 :
                          (depth == dslt_pkg::DEPTH_12) ? dslt_pkg::DIV_12 : dslt_pkg::DIV_8;
  wire [15:0] min_lines = (depth == dslt_pkg::DEPTH_16) ? dslt_pkg::MIN_LINES_16 :
                          (depth == dslt_pkg::DEPTH_12) ? dslt_pkg::MIN_LINES_12 :
                          dslt_pkg::MIN_LINES_8;
  // band limited: lines*1e6/(1024*div*line) in whole lines, rounded down
  wire [63:0] band_num  = lines_r * dslt_pkg::US_PER_S;
  wire [63:0] band_den  = dslt_pkg::LINES_REF * divisor * line_r;
  wire [63:0] band_n    = band_num / band_den;
  wire [63:0] band_t    = band_n * line_r;
  wire        banded    = wide && (lines_r >= {16'h0, min_lines});
  wire [47:0] plain_t   = exp_eff + (lines_r + dslt_pkg::LINE_EXTRA) * line_r;
  wire [31:0] frame_nxt = banded ? band_t[31:0] : plain_t[31:0];

  always_ff @(posedge clock) begin
    if (reset) begin
      frame_r  <= '0;
      explim_r <= '0;
    end else begin
      frame_r  <= frame_nxt;
      explim_r <= exp_hi;
    end
  end

  // ==========================================================================
  // microsecond time base, tick period rounded up
  logic [15:0] tick_cnt_r;
  wire         tick = tick_cnt_r == 16'(TICK_CYCLES - 1);
  always_ff @(posedge clock) begin
    if (reset || tick) tick_cnt_r <= '0;
    else               tick_cnt_r <= tick_cnt_r + 16'h1;
  end

  // trigger pin synchroniser; edge taken only from second stage onward
  logic trig_s1_r, trig_s2_r, trig_s3_r;
  always_ff @(posedge clock) begin
    if (reset) {trig_s1_r, trig_s2_r, trig_s3_r} <= 3'h0;
    else       {trig_s1_r, trig_s2_r, trig_s3_r} <= {trigger_in, trig_s1_r, trig_s2_r};
  end
  wire trig_edge = trig_s2_r & ~trig_s3_r;

  // ==========================================================================
  // frame sequencer: exposure then line by line readout
  dslt_frame_t fsm_r;
  logic [31:0] fcnt_r, lcnt_r, lidx_r;
  logic        start_r;
  wire start_ok = run & ((opmode == dslt_pkg::OPM_FREE) | start_r | trig_edge);
  wire line_end = tick && (lcnt_r + 32'h1 >= line_r);
  wire read_beg = (fsm_r == DSLT_EXPOSE) && tick && (fcnt_r + 32'h1 >= exp_eff);
  wire read_end = (fsm_r == DSLT_READ) && line_end && (lidx_r + 32'h1 >= lines_r);
  // line sync runs during exposure too, giving leading pulses
  wire hsync    = (fsm_r != DSLT_IDLE) && line_end;

  always_ff @(posedge clock) begin
    if (reset) start_r <= 1'b0;
    else if (!run) start_r <= 1'b0;
    else if (opmode == dslt_pkg::OPM_START && trig_edge) start_r <= 1'b1;
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      fsm_r  <= DSLT_IDLE;
      fcnt_r <= '0;
      lcnt_r <= '0;
      lidx_r <= '0;
    end else begin
      lcnt_r <= (fsm_r == DSLT_IDLE || line_end) ? '0 : (tick ? lcnt_r + 32'h1 : lcnt_r);
      case (fsm_r)
        DSLT_IDLE: begin
          fcnt_r <= '0;
          lidx_r <= '0;
          if (start_ok) fsm_r <= DSLT_EXPOSE;
        end
        DSLT_EXPOSE: begin
          fcnt_r <= tick ? fcnt_r + 32'h1 : fcnt_r;
          if (read_beg) fsm_r <= DSLT_READ;
        end
        DSLT_READ: begin
          if (line_end) lidx_r <= lidx_r + 32'h1;
          if (read_end) fsm_r <= DSLT_IDLE;
        end
        default: fsm_r <= DSLT_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // programmable pulse generator
  dslt_pulse_t pst_r;
  logic [31:0] pcnt_r;
  // reference select picks the arming event
  wire arm = (ref_sel == dslt_pkg::REF_READ_END) ? read_end :
             (ref_sel == dslt_pkg::REF_FRAME)    ? read_beg :
             (ref_sel == dslt_pkg::REF_LINE)     ? hsync : 1'b0;

  always_ff @(posedge clock) begin
    if (reset) begin
      pst_r  <= DSLT_P_IDLE;
      pcnt_r <= '0;
    end else begin
      case (pst_r)
        DSLT_P_IDLE: begin
          pcnt_r <= '0;
          if (arm) pst_r <= (delay_r == '0) ? DSLT_P_HIGH : DSLT_P_DELAY;
        end
        DSLT_P_DELAY: begin
          if (tick) pcnt_r <= pcnt_r + 32'h1;
          if (tick && pcnt_r + 32'h1 >= delay_r) begin
            pst_r  <= DSLT_P_HIGH;
            pcnt_r <= '0;
          end
        end
        DSLT_P_HIGH: begin
          if (tick) pcnt_r <= pcnt_r + 32'h1;
          if (tick && pcnt_r + 32'h1 >= width_r) pst_r <= DSLT_P_IDLE;
        end
        default: pst_r <= DSLT_P_IDLE;
      endcase
    end
  end

  // ==========================================================================
  // read mux and registered outputs
  wire [31:0] status_w = {27'h0, pst_r == DSLT_P_HIGH, fsm_r, refused_r, run};
  wire [31:0] rd_w =
    (avs_address == dslt_pkg::OFS_CTRL)   ? {22'h0, ctrl_r} :
    (avs_address == dslt_pkg::OFS_LINE)   ? line_r :
    (avs_address == dslt_pkg::OFS_LINES)  ? lines_r :
    (avs_address == dslt_pkg::OFS_PIXELS) ? pixels_r :
    (avs_address == dslt_pkg::OFS_EXPOSE) ? expose_r :
    (avs_address == dslt_pkg::OFS_DELAY)  ? delay_r :
    (avs_address == dslt_pkg::OFS_WIDTH)  ? width_r :
    (avs_address == dslt_pkg::OFS_FRAME)  ? frame_r :
    (avs_address == dslt_pkg::OFS_STATUS) ? status_w :
    (avs_address == dslt_pkg::OFS_EXPLIM) ? explim_r : 32'h0;

  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_r         <= '0;
      pulse_out       <= 1'b0;
      frame_active    <= 1'b0;
      line_sync       <= 1'b0;
      top_dir         <= 1'b0;
      bottom_dir      <= 1'b0;
      global_exposure <= 1'b0;
    end else begin
      if (avs_read && !ack_r) rdata_r <= rd_w;
      pulse_out       <= pst_r == DSLT_P_HIGH;
      frame_active    <= fsm_r == DSLT_READ;
      line_sync       <= hsync;
      top_dir         <= ctrl_r[dslt_pkg::CTRL_TOP_DIR];
      bottom_dir      <= ctrl_r[dslt_pkg::CTRL_BOT_DIR];
      global_exposure <= 1'b0;
    end
  end
  assign avs_readdata    = rdata_r;
  assign avs_waitrequest = wait_r;

  // ==========================================================================
  // checks
  a_no_global_exp: assert property (@(posedge clock) disable iff (reset)
    !global_exposure) else $error("global exposure raised");
  a_binning_refused: assert property (@(posedge clock) disable iff (reset)
    !ctrl_r[dslt_pkg::CTRL_BINNING]) else $error("binning accepted");
  a_width_range: assert property (@(posedge clock) disable iff (reset)
    width_r >= 32'h1 && width_r <= dslt_pkg::MAX_TIME_US) else $error("width out of range");
  a_exp_bound: assert property (@(posedge clock) disable iff (reset)
    exp_eff <= dslt_pkg::MAX_TIME_US && exp_eff <= exp_hi) else $error("exposure bound");
  a_arm_read_end: assert property (@(posedge clock) disable iff (reset)
    (pst_r == DSLT_P_IDLE && ref_sel == dslt_pkg::REF_READ_END && read_end)
    |=> pst_r != DSLT_P_IDLE) else $error("read end did not arm");
  a_arm_frame: assert property (@(posedge clock) disable iff (reset)
    (pst_r == DSLT_P_IDLE && ref_sel == dslt_pkg::REF_FRAME && read_beg)
    |=> pst_r != DSLT_P_IDLE) else $error("frame sync did not arm");
  a_arm_line: assert property (@(posedge clock) disable iff (reset)
    (pst_r == DSLT_P_IDLE && ref_sel == dslt_pkg::REF_LINE && hsync)
    |=> pst_r != DSLT_P_IDLE) else $error("line sync did not arm");
  a_pulse_follows: assert property (@(posedge clock) disable iff (reset)
    (pst_r == DSLT_P_HIGH) |=> pulse_out) else $error("pulse out lags");
  a_dir_follow: assert property (@(posedge clock) disable iff (reset)
    ##1 top_dir == $past(ctrl_r[dslt_pkg::CTRL_TOP_DIR])) else $error("direction lag");
  a_bus_answer: assert property (@(posedge clock) disable iff (reset)
    (avs_read && avs_waitrequest) |=> !avs_waitrequest) else $error("bus slow");
endmodule

/* verification/dslt_scanner.sv */
// behavioural model of the illumination scanner that watches the timing outputs
`timescale 1ns/1ps
module dslt_scanner (
  // clock
  input  wire logic clock,
  // timing outputs seen by the scanner
  input  wire logic pulse_out,
  input  wire logic line_sync,
  input  wire logic frame_active,
  // trigger back to the camera
  output logic      trigger_in
);
  // ==========================================================================
  // edge stamps and counters, read by the bench
  int   cyc, t_fa_rise, t_fa_fall, t_p_rise, width, dly_frame, dly_end;
  int   n_pulse, n_line, n_frame;
  logic p_q, fa_q;
  initial begin
    trigger_in = 1'b0;
    p_q = 1'b0;
    fa_q = 1'b0;
    cyc = 0;
  end
  // stamps are taken on the sampled value, so the one cycle output lag cancels out
  always @(posedge clock) begin
    cyc++;
    p_q <= pulse_out;
    fa_q <= frame_active;
    if (frame_active && !fa_q) begin
      t_fa_rise = cyc;
      n_frame++;
    end
    if (!frame_active && fa_q) t_fa_fall = cyc;
    if (line_sync) n_line++;
    if (pulse_out && !p_q) begin
      t_p_rise = cyc;
      dly_frame = cyc - t_fa_rise;
      dly_end = cyc - t_fa_fall;
    end
    if (!pulse_out && p_q) begin
      width = cyc - t_p_rise;
      n_pulse++;
    end
  end
  // clear the pulse and line counters before a measurement window
  task automatic clr();
    n_pulse = 0;
    n_line = 0;
  endtask
  // a clean trigger, held long enough for the two stage synchroniser
  task automatic fire();
    trigger_in <= 1'b1;
    repeat (4) @(posedge clock);
    trigger_in <= 1'b0;
    @(posedge clock);
  endtask
endmodule

/* verification/dual_sheet_line_timing_pulse_out_test.sv */
// self-checking bench for the dual sheet line timer
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin failures++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module dual_sheet_line_timing_pulse_out_test;
  logic        clock, reset, avs_read, avs_write, trigger_in, ge_bad;
  logic        pulse_out, frame_active, line_sync, top_dir, bottom_dir, global_exposure;
  logic        avs_waitrequest;
  logic [5:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdat;
  int          failures, cmp_count, cycles, mn, ln, px, n0;
  // ==========================================================================
  // clock, design and scanner
  initial clock = 1'b0;
  always #2 clock = ~clock;
  dslt_timer #(.TICK_CYCLES(2)) i_dslt_timer (
    .clock(clock), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .trigger_in(trigger_in), .pulse_out(pulse_out), .frame_active(frame_active),
    .line_sync(line_sync), .top_dir(top_dir), .bottom_dir(bottom_dir),
    .global_exposure(global_exposure));
  dslt_scanner i_dslt_scanner (.clock(clock), .pulse_out(pulse_out),
    .line_sync(line_sync), .frame_active(frame_active), .trigger_in(trigger_in));
  // hang guard and a watch on the output that must never rise
  always @(posedge clock) begin
    cycles++;
    if (!reset && global_exposure !== 1'b0) ge_bad <= 1'b1;
    if (cycles == 60000) begin
      failures++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    if (failures == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // one bus cycle; an edge passes after release so no signal is set twice at once
  task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] v);
    avs_address <= a;
    avs_writedata <= v;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clock);
    while (avs_waitrequest !== 1'b0) @(posedge clock);
    rdat = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `CHK(rdat, e)
  endtask
  // expected frame period in microseconds, exposure clamped first
  function automatic logic [31:0] frm(input int dp, input longint n, p, lp, ex);
    longint dv, lim, e;
    dv = dp == 0 ? 40 : dp == 1 ? 53 : 80;
    lim = n * lp;
    if (lim >= 10000000) lim = 10000000;
    e = ex < lp ? lp : ex > lim ? lim : ex;
    if (p > 512 && n >= (dp == 0 ? 8 : dp == 1 ? 16 : 48))
      return 32'((n * 1000000 / (1024 * dv * lp)) * lp);
    return 32'(e + (n + 10) * lp);
  endfunction
  // ==========================================================================
  // main sequence
  initial begin
    {avs_read, avs_write, ge_bad} = 3'h0;
    avs_address = 6'h00;
    avs_writedata = 32'h0;
    {failures, cmp_count, cycles} = 0;
    reset = 1'b1;
    repeat (16) @(posedge clock);
    reset <= 1'b0;
    @(posedge clock);
    rd_chk(dslt_pkg::OFS_LINE, 32'h0000_000A);
    rd_chk(dslt_pkg::OFS_LINES, 32'h0000_0400);
    rd_chk(dslt_pkg::OFS_EXPOSE, 32'h0000_2710);
    rd_chk(dslt_pkg::OFS_WIDTH, 32'h0000_000A);
    rd_chk(6'h3C, 32'h0000_0000);
    rd_chk(dslt_pkg::OFS_EXPLIM, 32'h0000_2800);
    // clamps at both ends of the line range, the top of exposure and delay, the bottom of width
    bus(1'b1, dslt_pkg::OFS_LINE, 32'h0001_86A1);
    rd_chk(dslt_pkg::OFS_LINE, 32'h0001_86A0);
    rd_chk(dslt_pkg::OFS_EXPLIM, 32'h0098_9680);
    bus(1'b1, dslt_pkg::OFS_LINE, 32'h0);
    rd_chk(dslt_pkg::OFS_LINE, 32'h0000_0001);
    bus(1'b1, dslt_pkg::OFS_EXPOSE, 32'h0098_9681);
    rd_chk(dslt_pkg::OFS_EXPOSE, 32'h0098_9680);
    bus(1'b1, dslt_pkg::OFS_DELAY, 32'h0098_9681);
    rd_chk(dslt_pkg::OFS_DELAY, 32'h0098_9680);
    bus(1'b1, dslt_pkg::OFS_WIDTH, 32'h0);
    rd_chk(dslt_pkg::OFS_WIDTH, 32'h0000_0001);
    // independent directions, then refused modes leave control untouched
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h20);
    @(posedge clock);
    `CHK({top_dir, bottom_dir}, 2'b10)
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h40);
    @(posedge clock);
    `CHK({top_dir, bottom_dir}, 2'b01)
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h200);
    rd_chk(dslt_pkg::OFS_CTRL, 32'h40);
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h180);
    rd_chk(dslt_pkg::OFS_CTRL, 32'h40);
    bus(1'b0, dslt_pkg::OFS_STATUS, 32'h0);
    `CHK(rdat[1], 1'b1)
    // frame period for every depth at band edges and a narrow frame
    bus(1'b1, dslt_pkg::OFS_LINE, 32'd10);
    bus(1'b1, dslt_pkg::OFS_EXPOSE, 32'd10000);
    for (int dp = 0; dp < 3; dp++) begin
      for (int k = 0; k < 4; k++) begin
        mn = dp == 0 ? 8 : dp == 1 ? 16 : 48;
        ln = k == 1 ? mn : k == 2 ? (dp == 2 ? 44 : 4) : 1024;
        px = k == 3 ? 512 : 2048;
        bus(1'b1, dslt_pkg::OFS_LINES, 32'(ln));
        bus(1'b1, dslt_pkg::OFS_PIXELS, 32'(px));
        bus(1'b1, dslt_pkg::OFS_CTRL, 32'(dp << dslt_pkg::CTRL_DEPTH_LO));
        rd_chk(dslt_pkg::OFS_FRAME, frm(dp, ln, px, 10, 10000));
      end
    end
    bus(1'b0, dslt_pkg::OFS_STATUS, 32'h0);
    `CHK(rdat[1], 1'b0)
    // pulse from frame start, then from read end: 3 tick delay, 5 tick width
    bus(1'b1, dslt_pkg::OFS_LINES, 32'd8);
    bus(1'b1, dslt_pkg::OFS_EXPOSE, 32'd20);
    bus(1'b1, dslt_pkg::OFS_DELAY, 32'd3);
    bus(1'b1, dslt_pkg::OFS_WIDTH, 32'd5);
    for (int r = 0; r < 2; r++) begin
      bus(1'b1, dslt_pkg::OFS_CTRL, r == 0 ? 32'h3 : 32'h1);
      n0 = i_dslt_scanner.n_pulse;
      while (i_dslt_scanner.n_pulse < n0 + 2) @(posedge clock);
      `CHK(i_dslt_scanner.width, 10)
      if (r == 0) `CHK(i_dslt_scanner.dly_frame inside {[6:11]}, 1'b1)
      else `CHK(i_dslt_scanner.dly_end inside {[6:11]}, 1'b1)
    end
    // a pulse for every line sync, through exposure as well as readout
    bus(1'b1, dslt_pkg::OFS_DELAY, 32'd0);
    bus(1'b1, dslt_pkg::OFS_WIDTH, 32'd1);
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h5);
    i_dslt_scanner.clr();
    repeat (400) @(posedge clock);
    `CHK(i_dslt_scanner.n_line >= 10, 1'b1)
    `CHK((i_dslt_scanner.n_pulse - i_dslt_scanner.n_line) inside {[-1:1]}, 1'b1)
    // edge trigger: no frame without a trigger, exactly one after it
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h81);
    repeat (300) @(posedge clock);
    n0 = i_dslt_scanner.n_frame;
    repeat (600) @(posedge clock);
    `CHK(i_dslt_scanner.n_frame - n0, 0)
    i_dslt_scanner.fire();
    repeat (600) @(posedge clock);
    `CHK(i_dslt_scanner.n_frame - n0, 1)
    // start trigger: idle until the first trigger, then free running
    bus(1'b1, dslt_pkg::OFS_CTRL, 32'h101);
    n0 = i_dslt_scanner.n_frame;
    repeat (300) @(posedge clock);
    `CHK(i_dslt_scanner.n_frame - n0, 0)
    i_dslt_scanner.fire();
    repeat (600) @(posedge clock);
    `CHK(i_dslt_scanner.n_frame - n0 >= 2, 1'b1)
    `CHK(ge_bad, 1'b0)
    end_of_test();
  end
endmodule
